// *** hw/mag_measure_top.sv ***
`timescale 1ns/1ps
`include "mag_defines.svh"
// Behaviour
// - answer slave address 0110 plus three fixed low bits
// - acknowledge address and written bytes by pulling data low on ninth clock
// - writing bit 0 of main control starts one x, y, z acquisition
// - status bit 0 goes high when all three axes are stored
// - results from index 00: x low, x high, y low, y high, z low, z high
// - register pointer advances by one after every streamed byte
// - repeated start with read bit; device acks then drives register data
// - writing bit 7 of main control starts recharging the storage capacitor
// - writing bit 5 fires a set pulse
// - writing bit 6 fires a reset pulse, opposite direction
// - axes convert in turn, each slot one third of measurement time
// - device returns to idle by itself after an acquisition
module mag_measure_top
   import mag_pkg::*;
#(
   parameter logic [2:0]  addr_low   = 3'h0,
   parameter int unsigned meas_us_00 = `MEAS_US_00,
   parameter int unsigned meas_us_01 = `MEAS_US_01,
   parameter int unsigned meas_us_10 = `MEAS_US_10,
   parameter int unsigned meas_us_11 = `MEAS_US_11
)
(
   // system
   input  wire logic        mclk,
   input  wire logic        rstn,
   // two-wire link
   input  wire logic        scl,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // converter front end
   input  wire logic [1:0]  resolution_select,
   input  wire logic [15:0] adc_value,
   output logic             conv_active,
   output logic [1:0]       conv_axis,
   output logic             sample_strobe,
   // magnetizing driver
   output logic             recharge,
   output logic             set_pulse,
   output logic             reset_pulse
);
   localparam int unsigned slot_00 = meas_us_00 * `CLK_MHZ / `NUM_AXES;
   localparam int unsigned slot_01 = meas_us_01 * `CLK_MHZ / `NUM_AXES;
   localparam int unsigned slot_10 = meas_us_10 * `CLK_MHZ / `NUM_AXES;
   localparam int unsigned slot_11 = meas_us_11 * `CLK_MHZ / `NUM_AXES;
   localparam int unsigned pulse_cyc = `SR_PULSE_NS * `CLK_MHZ / 1000;
   localparam logic [1:0]  last_axis = 2'(`NUM_AXES - 1);

   mag_link_if lk ();

   // pin and link synchronisers
   logic       scl_s1_ff;
   logic       scl_s2_ff;
   logic       sda_s1_ff;
   logic       sda_s2_ff;
   logic       sda_s3_ff;
   logic       frame_rst_n_ff;
   logic       dev_rst_n_ff;
   logic       tgl_s1_ff;
   logic       tgl_s2_ff;
   logic       tgl_s3_ff;
   logic [7:0] ptr_s1_ff;
   logic [7:0] ptr_s2_ff;
   logic [1:0] res_s1_ff;
   logic [1:0] res_s2_ff;

   // register file and sequencer
   logic [7:0]       result_ff [`RESULT_BYTES];
   logic [7:0]       rd_data_ff;
   seq_e             state_ff;
   seq_e             nxt_state;
   logic [`CNT_W-1:0] cnt_ff;
   logic [`CNT_W-1:0] nxt_cnt;
   logic [1:0]       axis_ff;
   logic [1:0]       nxt_axis;
   logic [1:0]       res_ff;
   logic             done_ff;
   logic             dir_reset_ff;
   logic             recharge_ff;
   logic             set_pulse_ff;
   logic             reset_pulse_ff;
   logic             conv_active_ff;
   logic [1:0]       conv_axis_ff;
   logic             sample_strobe_ff;
   logic             sda_o_ff;

   // start: data falls while clock high; stop: data rises while clock high
   wire start_det = scl_s2_ff && sda_s3_ff && !sda_s2_ff;
   wire stop_det  = scl_s2_ff && !sda_s3_ff && sda_s2_ff;

   // write handshake: data is held by the link until the next byte
   wire wr_pulse = tgl_s2_ff ^ tgl_s3_ff;
   wire wr_ctrl  = wr_pulse && (lk.wr_idx == `IDX_CTRL);
   wire idle     = (state_ff == st_idle);

   wire cmd_meas   = wr_ctrl && lk.wr_data[`CTRL_TAKE_SAMPLE] && idle;
   wire cmd_set    = wr_ctrl && lk.wr_data[`CTRL_SET];
   wire cmd_reset  = wr_ctrl && lk.wr_data[`CTRL_RESET];
   wire cmd_refill = wr_ctrl && lk.wr_data[`CTRL_REFILL];
   wire pulse_start = idle && !cmd_meas && (cmd_set || cmd_reset);

   wire [`CNT_W-1:0] slot_cyc =
      (res_ff == 2'h0) ? `CNT_W'(slot_00 - 1) :
      (res_ff == 2'h1) ? `CNT_W'(slot_01 - 1) :
      (res_ff == 2'h2) ? `CNT_W'(slot_10 - 1) :
                         `CNT_W'(slot_11 - 1);

   wire slot_end   = (state_ff == st_conv) && (cnt_ff == slot_cyc);
   wire last_slot  = slot_end && (axis_ff == last_axis);
   wire pulse_end  = (state_ff == st_pulse) &&
                     (cnt_ff == `CNT_W'(pulse_cyc - 1));
   wire nxt_dir    = pulse_start ? !cmd_set : dir_reset_ff;
   wire nxt_done   = last_slot || (done_ff && !cmd_meas);
   wire nxt_charge = cmd_refill || (recharge_ff && !pulse_start);

   wire [2:0] lo_slot = {axis_ff, 1'b0};
   wire [2:0] hi_slot = {axis_ff, 1'b1};

   wire [7:0] status_view = {7'h00, done_ff};
   wire [7:0] ctrl_view   = {recharge_ff, reset_pulse_ff, set_pulse_ff,
                             4'h0, conv_active_ff};
   wire [7:0] rd_mux =
      (ptr_s2_ff < 8'(`RESULT_BYTES)) ? result_ff[ptr_s2_ff[2:0]] :
      (ptr_s2_ff == `IDX_STATUS)      ? status_view :
      (ptr_s2_ff == `IDX_CTRL)        ? ctrl_view :
                                        8'h00;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
      end
      else
      begin
         scl_s1_ff <= scl;
         scl_s2_ff <= scl_s1_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
      end
   end

   // the link clock stops outside frames, so the frame boundary is
   // taken here and handed back as a reset; it lifts while scl is high
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         frame_rst_n_ff <= 1'b0;
         dev_rst_n_ff   <= 1'b0;
      end
      else
      begin
         frame_rst_n_ff <= !(start_det || stop_det);
         dev_rst_n_ff   <= 1'b1;
      end
   end

   // pointer is quasi-static: it moves only once per nine scl clocks
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         tgl_s1_ff <= 1'b0;
         tgl_s2_ff <= 1'b0;
         tgl_s3_ff <= 1'b0;
         ptr_s1_ff <= 8'h00;
         ptr_s2_ff <= 8'h00;
         res_s1_ff <= 2'h0;
         res_s2_ff <= 2'h0;
      end
      else
      begin
         tgl_s1_ff <= lk.wr_tgl;
         tgl_s2_ff <= tgl_s1_ff;
         tgl_s3_ff <= tgl_s2_ff;
         ptr_s1_ff <= lk.ptr;
         ptr_s2_ff <= ptr_s1_ff;
         res_s1_ff <= resolution_select;
         res_s2_ff <= res_s1_ff;
      end
   end

   // measure, set and reset commands that land while busy are dropped; refill still applies; the byte is still acked
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_axis  = axis_ff;
      unique case (state_ff)
         st_idle:
         begin
            nxt_cnt  = '0;
            if (cmd_meas)
            begin
               nxt_state = st_conv;
               nxt_axis  = 2'h0;
            end
            else if (pulse_start)
               nxt_state = st_pulse;
         end
         st_conv:
         begin
            if (last_slot)
               nxt_state = st_idle;
            else if (slot_end)
            begin
               nxt_cnt  = '0;
               nxt_axis = axis_ff + 2'h1;
            end
            else
               nxt_cnt = cnt_ff + `CNT_W'(1);
         end
         st_pulse:
         begin
            if (pulse_end)
               nxt_state = st_idle;
            else
               nxt_cnt = cnt_ff + `CNT_W'(1);
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff     <= st_idle;
         cnt_ff       <= '0;
         axis_ff      <= 2'h0;
         res_ff       <= 2'h0;
         done_ff      <= 1'b0;
         dir_reset_ff <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         axis_ff      <= nxt_axis;
         res_ff       <= cmd_meas ? res_s2_ff : res_ff;
         done_ff      <= nxt_done;
         dir_reset_ff <= nxt_dir;
      end
   end

   // the pin drivers are registered from the next state, so they line up with the sequencer state; only the strobe lags slot_end by one cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         recharge_ff      <= 1'b0;
         set_pulse_ff     <= 1'b0;
         reset_pulse_ff   <= 1'b0;
         conv_active_ff   <= 1'b0;
         conv_axis_ff     <= 2'h0;
         sample_strobe_ff <= 1'b0;
         sda_o_ff         <= 1'b0;
      end
      else
      begin
         recharge_ff      <= nxt_charge;
         set_pulse_ff     <= (nxt_state == st_pulse) && !nxt_dir;
         reset_pulse_ff   <= (nxt_state == st_pulse) && nxt_dir;
         conv_active_ff   <= (nxt_state == st_conv);
         conv_axis_ff     <= nxt_axis;
         sample_strobe_ff <= slot_end;
         sda_o_ff         <= 1'b0;
      end
   end

   // each axis result lands low byte first at an even index
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < `RESULT_BYTES; i++)
            result_ff[i] <= 8'h00;
      end
      else if (slot_end)
      begin
         result_ff[lo_slot] <= adc_value[7:0];
         result_ff[hi_slot] <= adc_value[15:8];
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rd_data_ff <= 8'h00;
      else
         rd_data_ff <= rd_mux;
   end

   assign lk.dev_rst_n   = dev_rst_n_ff;
   assign lk.frame_rst_n = frame_rst_n_ff;
   assign lk.rd_data     = rd_data_ff;

   i2c_link_engine #(
      .addr_low (addr_low)
   ) u_link (
      .scl    (scl),
      .sda_i  (sda_i),
      .sda_oe (sda_oe),
      .lk     (lk.link)
   );

   assign sda_o         = sda_o_ff;
   assign conv_active   = conv_active_ff;
   assign conv_axis     = conv_axis_ff;
   assign sample_strobe = sample_strobe_ff;
   assign recharge      = recharge_ff;
   assign set_pulse     = set_pulse_ff;
   assign reset_pulse   = reset_pulse_ff;

endmodule // mag_measure_top

// *** hw/mag_defines.svh ***
`ifndef MAG_DEFINES_SVH
`define MAG_DEFINES_SVH

// fixed upper nibble of the 7-bit slave address
`define DEV_ADDR_HI     4'h6

// register indices
`define IDX_X_LOW       8'h00
`define IDX_STATUS      8'h06
`define IDX_CTRL        8'h07
`define RESULT_BYTES    6

// main_control command bits
`define CTRL_TAKE_SAMPLE 0
`define CTRL_SET         5
`define CTRL_RESET       6
`define CTRL_REFILL      7

// status_flags bits
`define STAT_DONE        0

// link byte framing, bit counter values
`define LAST_DATA_BIT    4'h7
`define ACK_BIT          4'h8

// timing
`define CLK_MHZ          100
`define NUM_AXES         3
`define MEAS_US_00       7920
`define MEAS_US_01       4080
`define MEAS_US_10       2160
`define MEAS_US_11       1200
`define SR_PULSE_NS      1000
`define CNT_W            20

`endif

// *** hw/mag_pkg.sv ***
package mag_pkg;

   typedef enum logic [2:0] {
      ph_addr,
      ph_reg,
      ph_wdata,
      ph_rdata,
      ph_idle
   } phase_e;

   typedef enum logic [1:0] {
      st_idle,
      st_conv,
      st_pulse
   } seq_e;

endpackage

// *** hw/mag_link_if.sv ***
`timescale 1ns/1ps
interface mag_link_if;
   logic       dev_rst_n;
   logic       frame_rst_n;
   logic [7:0] ptr;
   logic [7:0] rd_data;
   logic       wr_tgl;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;

   modport link (
      input  dev_rst_n,
      input  frame_rst_n,
      input  rd_data,
      output ptr,
      output wr_tgl,
      output wr_idx,
      output wr_data
   );

   modport core (
      output dev_rst_n,
      output frame_rst_n,
      output rd_data,
      input  ptr,
      input  wr_tgl,
      input  wr_idx,
      input  wr_data
   );
endinterface

// *** hw/i2c_link_engine.sv ***
`timescale 1ns/1ps
`include "mag_defines.svh"
module i2c_link_engine
   import mag_pkg::*;
#(
   parameter logic [2:0] addr_low = 3'h0
)
(
   // link pins
   input  wire logic scl,
   input  wire logic sda_i,
   output logic      sda_oe,
   // register side
   mag_link_if.link  lk
);
   phase_e     phase_ff;
   phase_e     nxt_phase;
   logic [3:0] bit_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] ptr_ff;
   logic [7:0] wr_idx_ff;
   logic [7:0] wr_data_ff;
   logic       wr_tgl_ff;
   logic       rw_ff;
   logic       ack_ff;
   logic       sda_oe_ff;

   wire [7:0] byte_in  = {shift_ff[6:0], sda_i};
   wire       byte_end = (bit_ff == `LAST_DATA_BIT);
   wire       ack_bit  = (bit_ff == `ACK_BIT);
   wire       addr_hit = (byte_in[7:1] == {`DEV_ADDR_HI, addr_low});
   wire       want_ack = byte_end &&
                         ((phase_ff == ph_addr && addr_hit) ||
                          phase_ff == ph_reg || phase_ff == ph_wdata);
   wire       wr_byte  = byte_end && phase_ff == ph_wdata;
   // a read pointer steps at the eighth bit, so the next byte has the
   // whole ack clock to cross into the core clock and back
   wire       step_ptr = (ack_bit && phase_ff == ph_wdata) ||
                         (byte_end && phase_ff == ph_rdata);

   always_comb
   begin
      nxt_phase = phase_ff;
      if (byte_end && phase_ff == ph_addr && !addr_hit)
         nxt_phase = ph_idle;
      else if (ack_bit)
      begin
         unique case (phase_ff)
            ph_addr:  nxt_phase = rw_ff ? ph_rdata : ph_reg;
            ph_reg:   nxt_phase = ph_wdata;
            ph_wdata: nxt_phase = ph_wdata;
            // a master nack ends the stream until the next start
            ph_rdata: nxt_phase = sda_i ? ph_idle : ph_rdata;
            ph_idle:  nxt_phase = ph_idle;
         endcase
      end
   end

   // per-frame state: cleared by every start or stop
   always_ff @(posedge scl or negedge lk.frame_rst_n)
   begin
      if (!lk.frame_rst_n)
      begin
         phase_ff <= ph_addr;
         bit_ff   <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff    <= 1'b0;
         ack_ff   <= 1'b0;
      end
      else
      begin
         phase_ff <= nxt_phase;
         bit_ff   <= ack_bit ? 4'h0 : bit_ff + 4'h1;
         shift_ff <= byte_in;
         rw_ff    <= (byte_end && phase_ff == ph_addr) ? sda_i : rw_ff;
         ack_ff   <= want_ack;
      end
   end

   // pointer and write handshake survive repeated starts
   always_ff @(posedge scl or negedge lk.dev_rst_n)
   begin
      if (!lk.dev_rst_n)
      begin
         ptr_ff     <= 8'h00;
         wr_idx_ff  <= 8'h00;
         wr_data_ff <= 8'h00;
         wr_tgl_ff  <= 1'b0;
      end
      else
      begin
         if (byte_end && phase_ff == ph_reg)
            ptr_ff <= byte_in;
         else if (step_ptr)
            ptr_ff <= ptr_ff + 8'h01;
         if (wr_byte)
         begin
            wr_idx_ff  <= ptr_ff;
            wr_data_ff <= byte_in;
            wr_tgl_ff  <= ~wr_tgl_ff;
         end
      end
   end

   // drive on the falling edge so data is stable across scl high
   always_ff @(negedge scl or negedge lk.frame_rst_n)
   begin
      if (!lk.frame_rst_n)
      begin
         sda_oe_ff <= 1'b0;
         tx_ff     <= 8'h00;
      end
      else if (ack_bit)
         sda_oe_ff <= ack_ff;
      else if (phase_ff == ph_rdata && bit_ff == 4'h0)
      begin
         // rd_data settles in a few mclk cycles, inside the stretched scl low phase before the ack clock
         tx_ff     <= lk.rd_data;
         sda_oe_ff <= ~lk.rd_data[7];
      end
      else if (phase_ff == ph_rdata)
      begin
         tx_ff     <= {tx_ff[6:0], 1'b0};
         sda_oe_ff <= ~tx_ff[6];
      end
      else
         sda_oe_ff <= 1'b0;
   end

   assign sda_oe     = sda_oe_ff;
   assign lk.ptr     = ptr_ff;
   assign lk.wr_tgl  = wr_tgl_ff;
   assign lk.wr_idx  = wr_idx_ff;
   assign lk.wr_data = wr_data_ff;

endmodule // i2c_link_engine

// *** dv/mag_measure_props.sv ***
`timescale 1ns/1ps
module mag_measure_props
   import mag_pkg::*;
(
   // system
   input wire logic       mclk,
   input wire logic       rstn,
   // watched outputs
   input wire logic       sda_o,
   input wire logic       conv_active,
   input wire logic [1:0] conv_axis,
   input wire logic       sample_strobe,
   input wire logic       recharge,
   input wire logic       set_pulse,
   input wire logic       reset_pulse
);
   logic [7:0] pcnt_ff;
   logic [1:0] scnt_ff;
   wire  [7:0] nxt_pcnt = (set_pulse | reset_pulse) ? pcnt_ff + 8'h01 : 8'h00;
   // strobe count of the running acquisition, kept until conversion ends
   wire  [1:0] nxt_scnt = (!conv_active && !sample_strobe) ? 2'h0
                        : scnt_ff + {1'b0, sample_strobe};

   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         pcnt_ff <= 8'h00;
         scnt_ff <= 2'h0;
      end
      else
      begin
         pcnt_ff <= nxt_pcnt;
         scnt_ff <= nxt_scnt;
      end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   pulse_excl_a: assert property (!(set_pulse && reset_pulse))
      else $error("set and reset pulses overlap");
   pulse_width_a: assert property (($fell(set_pulse) || $fell(reset_pulse))
      |-> pcnt_ff == 8'h64) else $error("magnetizing pulse width wrong");
   recharge_drop_a: assert property (($rose(set_pulse) || $rose(reset_pulse))
      |-> !recharge) else $error("recharge still high at pulse");
   busy_quiet_a: assert property (conv_active |-> !(set_pulse || reset_pulse))
      else $error("pulse fired during conversion");
   // the last strobe lands in the cycle in which the conversion ends
   strobe_conv_a: assert property (sample_strobe |-> $past(conv_active))
      else $error("sample strobe outside conversion");
   strobe_gap_a: assert property (sample_strobe |=> !sample_strobe [*8])
      else $error("axis slots too close");
   first_axis_a: assert property ($rose(conv_active) |-> conv_axis == 2'h0)
      else $error("conversion did not start on x");
   strobe_count_a: assert property ($fell(conv_active)
      |-> sample_strobe && scnt_ff == 2'h2)
      else $error("conversion ended without three axes");
   idle_return_a: assert property ((sample_strobe && scnt_ff == 2'h2)
      |-> ##[1:3] !conv_active) else $error("no return to idle");
   sda_drain_a: assert property (sda_o == 1'b0)
      else $error("data line driven high");
endmodule // mag_measure_props

bind mag_measure_top mag_measure_props u_mag_measure_props (
   .mclk(mclk), .rstn(rstn), .sda_o(sda_o), .conv_active(conv_active),
   .conv_axis(conv_axis), .sample_strobe(sample_strobe),
   .recharge(recharge), .set_pulse(set_pulse), .reset_pulse(reset_pulse));

// *** dv/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model
(
   // two-wire bus
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   localparam int half = 15;
   localparam int hold = 200;

   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // long holds: the core clock must see start and stop on slowed copies
   task automatic start();
      #3 sda_pull = 1'b0;
      #half scl = 1'b1;
      #hold sda_pull = 1'b1;
      #hold scl = 1'b0;
   endtask

   task automatic stop();
      #3 sda_pull = 1'b1;
      #half scl = 1'b1;
      #hold sda_pull = 1'b0;
      #hold;
   endtask

   task automatic bit_io(input logic b, output logic r);
      #3 sda_pull = !b;
      #(half - 3) scl = 1'b1;
      r = sda;
      #half scl = 1'b0;
   endtask

   // low phase stretched before the ninth clock so read data can settle
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], b);
         q[i] = b;
      end
      #60;
      bit_io(last, ack);
   endtask
endmodule // i2c_host_model

// *** dv/magnetometer_measure_setreset_seq_bench.sv ***
`timescale 1ns/1ps
module magnetometer_measure_setreset_seq_bench;
   localparam logic [2:0] addr_low = 3'h5;
   localparam int         mus[4]   = '{12, 3, 2, 1};
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        scl;
   logic        sda_pull;
   logic        sda_o;
   logic        sda_oe;
   logic [1:0]  resolution_select = 2'h0;
   logic [15:0] adc_value = 16'h0000;
   logic        conv_active;
   logic [1:0]  conv_axis;
   logic        sample_strobe;
   logic        recharge;
   logic        set_pulse;
   logic        reset_pulse;
   wire         sda = !(sda_oe === 1'b1 || sda_pull);
   int          mismatches = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          n_set = 0;
   int          n_rst = 0;
   logic [15:0] cap[$];
   logic [15:0] adc_d;
   logic [7:0]  xk[2];
   logic [7:0]  cx[2];
   int          stb[$];
   logic [7:0]  exp_q[$];
   string       nam_q[$];
   logic [7:0]  got;
   logic        ack;
   event        got_ev;

   always #5 mclk = ~mclk;

   mag_measure_top #(.addr_low(addr_low), .meas_us_00(mus[0]),
      .meas_us_01(mus[1]), .meas_us_10(mus[2]), .meas_us_11(mus[3]))
   u_mag_measure_top (.mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .resolution_select(resolution_select),
      .adc_value(adc_value), .conv_active(conv_active),
      .conv_axis(conv_axis), .sample_strobe(sample_strobe),
      .recharge(recharge), .set_pulse(set_pulse),
      .reset_pulse(reset_pulse));

   i2c_host_model u_i2c_host_model (.scl(scl), .sda_pull(sda_pull),
      .sda(sda));

   initial
   begin
      void'($urandom(74));
      forever
      begin
         @(negedge mclk);
         adc_value = 16'($urandom);
      end
   end

   // the result is taken at the edge that raises the strobe, a cycle early
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      adc_d <= adc_value;
      if (sample_strobe === 1'b1)
      begin
         cap.push_back(adc_d);
         stb.push_back(cyc);
      end
      if (set_pulse === 1'b1)
         n_set <= n_set + 1;
      if (reset_pulse === 1'b1)
         n_rst <= n_rst + 1;
   end

   always @(got_ev)
      if (exp_q.size() > 0)
         check(nam_q.pop_front(), got, exp_q.pop_front());

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic xb(input logic [7:0] d, input logic last);
      u_i2c_host_model.xfer(d, last, got, ack);
   endtask

   task automatic head(input logic [7:0] idx);
      u_i2c_host_model.start();
      xb({4'h6, addr_low, 1'b0}, 1'b1);
      check("addr ack", ack, 1'b0);
      xb(idx, 1'b1);
      check("index ack", ack, 1'b0);
   endtask

   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
      head(idx);
      xb(d, 1'b1);
      check("data ack", ack, 1'b0);
      u_i2c_host_model.stop();
   endtask

   task automatic rd_regs(input logic [7:0] idx, input int n);
      head(idx);
      u_i2c_host_model.start();
      xb({4'h6, addr_low, 1'b1}, 1'b1);
      check("read ack", ack, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         xb(8'hFF, i == n - 1);
         ->got_ev;
      end
      u_i2c_host_model.stop();
   endtask

   initial
   begin
      int s0;
      int r0;
      int n;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      repeat (10) @(negedge mclk);
      for (int a = 0; a < 8; a++)
      begin
         u_i2c_host_model.start();
         xb({4'h6, 3'(a), 1'b0}, 1'b1);
         u_i2c_host_model.stop();
         check("addr match", ack, 3'(a) != addr_low);
      end
      $display("address test done");
      // slowest resolution last, so a stale done flag is there to be cleared
      for (int r = 3; r >= 0; r--)
      begin
         @(negedge mclk);
         resolution_select = 2'(r);
         cap.delete();
         stb.delete();
         s0 = n_set;
         wr_reg(8'h07, 8'h01);
         rd_regs(8'h06, 1);
         if (r == 0)
         begin
            check("done cleared", got[0], 1'b0);
            wr_reg(8'h07, 8'h20);
         end
         n = 0;
         while (got[0] !== 1'b1 && n < 50)
         begin
            rd_regs(8'h06, 1);
            n++;
         end
         check("done", got[0], 1'b1);
         check("idle", conv_active, 1'b0);
         check("busy set", n_set - s0, 0);
         check("axes", stb.size(), 3);
         if (stb.size() == 3)
         begin
            check("slot", stb[1] - stb[0], mus[r] * 100 / 3);
            check("slot", stb[2] - stb[1], mus[r] * 100 / 3);
            for (int i = 0; i < 6; i++)
            begin
               exp_q.push_back(cap[i / 2][8 * (i % 2) +: 8]);
               nam_q.push_back("result byte");
            end
            rd_regs(8'h00, 6);
         end
         $display("measure test %0d done", r);
      end
      for (int k = 0; k < 2; k++)
      begin
         s0 = n_set;
         r0 = n_rst;
         wr_reg(8'h07, 8'h80);
         check("recharge on", recharge, 1'b1);
         repeat (20) @(negedge mclk);
         wr_reg(8'h07, k == 0 ? 8'h20 : 8'h40);
         repeat (150) @(negedge mclk);
         check("recharge off", recharge, 1'b0);
         check("set cycles", n_set - s0, k == 0 ? 100 : 0);
         check("reset cycles", n_rst - r0, k == 0 ? 0 : 100);
         resolution_select = 2'h3;
         cap.delete();
         wr_reg(8'h07, 8'h01);
         repeat (150) @(negedge mclk);
         cx[k] = (cap.size() > 0) ? cap[0][7:0] : 8'h00;
         exp_q.push_back(cx[k]);
         nam_q.push_back("x low");
         rd_regs(8'h00, 1);
         xk[k] = got;
      end
      check("offset", (9'(xk[0]) + 9'(xk[1])) >> 1,
            (9'(cx[0]) + 9'(cx[1])) >> 1);
      $display("set reset test done");
      stop_test();
   end

   initial
   begin
      #500000;
      mismatches++;
      stop_test();
   end
endmodule // magnetometer_measure_setreset_seq_bench
